// ==== bench/acr_checker.sv ====
// Port assertions of the calibration and readout block.
`timescale 1ns/10ps
module acr_checker #(
    parameter int ISO_XFER_CYCLES = 100
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_sync_reset_n,
    input wire logic i_ready_format_bit,
    input wire logic i_cfg_write,
    input wire logic i_spi_cs_n,
    input wire logic o_spi_miso_oe,
    input wire logic o_data_ready_out_n,
    input wire logic o_resync_flag,
    input wire logic o_secondary_fail_flag
);
    // --------------------
    // Ages of input events
    // --------------------
    typedef struct packed {
        logic [7:0] wr;
        logic [7:0] cs;
        logic [7:0] sy;
        logic       sync;
    } acr_age_t;
    acr_age_t a_q;
    acr_age_t a_d;

    // Ages saturate so an idle stretch never wraps to a fresh event
    always_comb
    begin
        a_d      = a_q;
        a_d.sync = i_sync_reset_n;
        a_d.wr   = i_cfg_write ? 8'h00 : a_q.wr + 8'(a_q.wr != 8'hFF);
        a_d.cs   = !i_spi_cs_n ? 8'h00 : a_q.cs + 8'(a_q.cs != 8'hFF);
        a_d.sy   = (a_q.sync && !i_sync_reset_n) ? 8'h00 : a_q.sy + 8'(a_q.sy != 8'hFF);
    end

    // Reset to the oldest age: nothing has happened yet
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            a_q <= {8'hFF, 8'hFF, 8'hFF, 1'b1};
        else
            a_q <= a_d;
    end

    default clocking acr_cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // Pulse-format ready: fall, one more low cycle, then high again
    sequence s_pulse_fall;
        $fell(o_data_ready_out_n) && i_ready_format_bit && $past(i_ready_format_bit, 4);
    endsequence
    sequence s_pulse_rest;
        !o_data_ready_out_n ##1 o_data_ready_out_n;
    endsequence

    chk_miso_release: assert property (i_spi_cs_n |-> !o_spi_miso_oe)
        else $error("data output driven while deselected");
    chk_oe_select: assert property ($rose(o_spi_miso_oe) |-> !i_spi_cs_n)
        else $error("data output enabled without select");
    chk_secfail_set: assert property (i_cfg_write |=> o_secondary_fail_flag)
        else $error("fail flag missing after write");
    chk_secfail_span: assert property (
        o_secondary_fail_flag == (int'(a_q.wr) < ISO_XFER_CYCLES))
        else $error("fail flag span wrong");
    chk_pulse_width: assert property (s_pulse_fall |=> s_pulse_rest)
        else $error("ready pulse width wrong");
    chk_level_hold: assert property (
        $rose(o_data_ready_out_n) && !i_ready_format_bit && !$past(i_ready_format_bit, 4)
        |-> a_q.cs < 8'h10)
        else $error("ready released without a read");
    chk_resync_cause: assert property ($rose(o_resync_flag) |-> a_q.sy < 8'h20)
        else $error("resync flag without a sync edge");
    chk_load_idle: assert property ($fell(o_data_ready_out_n) |-> a_q.cs != 8'h00)
        else $error("ready fell while link busy");
endmodule

bind acr_top acr_checker #(.ISO_XFER_CYCLES(ISO_XFER_CYCLES)) acr_checker_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sync_reset_n(i_sync_reset_n),
    .i_ready_format_bit(i_ready_format_bit), .i_cfg_write(i_cfg_write),
    .i_spi_cs_n(i_spi_cs_n), .o_spi_miso_oe(o_spi_miso_oe),
    .o_data_ready_out_n(o_data_ready_out_n), .o_resync_flag(o_resync_flag),
    .o_secondary_fail_flag(o_secondary_fail_flag)
);

// ==== bench/acr_host_model.sv ====
// Host controller model: selects the device and clocks frames out of it.
`timescale 1ns/10ps
module acr_host_model (
    input  wire logic i_clk_sys,
    input  wire logic i_miso,
    input  wire logic i_miso_oe,
    output logic      o_sclk,
    output logic      o_cs_n
);
    logic last_q;
    logic line;

    // Released line shows the inverse of the last bit, so stale data fails
    assign line = i_miso_oe ? i_miso : ~last_q;

    // Idle: link clock parked low, device deselected
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        last_q = 1'b0;
    end

    // Link clock runs only inside a frame, 6 ns per bit
    task automatic read_bits(input int nbits, output logic [95:0] r);
        r = '0;
        @(negedge i_clk_sys);
        o_cs_n = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        for (int k = 0; k < nbits; k++)
        begin
            #3 o_sclk = 1'b1;
            #3 o_sclk = 1'b0;
            r      = {r[94:0], line};
            last_q = line;
        end
        @(negedge i_clk_sys);
        o_cs_n = 1'b1;
        repeat (3) @(negedge i_clk_sys);
    endtask
endmodule

// ==== bench/test_adc_calibration_readout.sv ====
// Self-checking bench of the calibration and readout block.
`timescale 1ns/10ps
module test_adc_calibration_readout;
    localparam int ISO = 4;
    logic                     clk;
    logic                     rst     = 1'b1;
    logic                     conv    = 1'b0;
    logic                     sync_n  = 1'b1;
    acr_pkg::acr_chan_words_t raw     = '0;
    acr_pkg::acr_cal_high_t   off_hi  = '0;
    acr_pkg::acr_cal_low_t    off_lo  = '0;
    acr_pkg::acr_cal_high_t   gn_hi   = '0;
    acr_pkg::acr_cal_low_t    gn_lo   = '0;
    acr_pkg::acr_phase_t      phase   = '0;
    logic                     fmt     = 1'b0;
    logic                     cfg_wr  = 1'b0;
    logic                     ramp_on = 1'b0;
    logic                     sclk, cs_n, miso, miso_oe, data_ready_out_n, resync, secfail, ovf;
    logic [95:0]              f, g;
    int                       cdiv = 0, ramp = 0, n;
    int                       fail_count = 0;
    int                       checked    = 0;

    acr_top #(.PERIOD_CLKS(8), .ISO_XFER_CYCLES(ISO), .FIFO_DEPTH(8)) acr_top_inst (
        .i_clk_sys(clk), .i_rst(rst), .i_converter_clock_in(conv),
        .i_sync_reset_n(sync_n), .i_raw_sample(raw),
        .i_chan_offset_cal_high(off_hi), .i_chan_offset_cal_low(off_lo),
        .i_chan_gain_cal_high(gn_hi), .i_chan_gain_cal_low(gn_lo),
        .i_chan_phase_field(phase), .i_ready_format_bit(fmt), .i_cfg_write(cfg_wr),
        .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
        .o_data_ready_out_n(data_ready_out_n), .o_resync_flag(resync),
        .o_secondary_fail_flag(secfail), .o_overflow_flag(ovf)
    );
    acr_host_model acr_host_model_inst (
        .i_clk_sys(clk), .i_miso(miso), .i_miso_oe(miso_oe), .o_sclk(sclk), .o_cs_n(cs_n)
    );

    // --------------------
    // Clocks and helpers
    // --------------------
    // System clock, 20 ns period
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Converter clock of eight system cycles; the ramp marks each rise
    always @(negedge clk)
    begin
        cdiv = (cdiv + 1) % 8;
        conv = (cdiv < 4);
        if (ramp_on && cdiv == 0)
        begin
            raw  = {24'(ramp), 24'(ramp), 24'(ramp)};
            ramp = ramp + 1;
        end
    end

    // Expected word: offset removed, 1.23 gain, saturated to 24 bits
    function automatic logic [23:0] cal(input logic [23:0] r, input logic [23:0] o,
                                        input logic [23:0] gn);
        longint p;
        p = ((longint'($signed(r)) - longint'($signed(o))) * longint'(gn)) >>> 23;
        if (p > 64'sh0000_0000_007F_FFFF)
            return 24'h7F_FFFF;
        if (p < -64'sh0000_0000_0080_0000)
            return 24'h80_0000;
        return p[23:0];
    endfunction

    task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Bounded wait for data ready; running out ends the run
    task automatic wait_data_ready_out();
        n = 0;
        while (data_ready_out_n !== 1'b0 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 400)
        begin
            chk(96'h0, 96'h1, "data ready timeout");
            print_verdict();
        end
    endtask

    task automatic rd(input int nbits, output logic [95:0] r);
        wait_data_ready_out();
        acr_host_model_inst.read_bits(nbits, r);
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_calib();
        logic [23:0] rv [3];
        logic [23:0] ov [3];
        logic [23:0] gv [3];
        logic [95:0] e;
        rv = '{24'h10_0000, 24'h20_0000, 24'h70_0000};
        ov = '{24'h00_1000, 24'hFF_FF00, 24'h00_0000};
        gv = '{24'h80_0000, 24'hC0_0000, 24'hFF_FFFF};
        e  = '0;
        for (int k = 0; k < 3; k++)
        begin
            raw[k]    = rv[k];
            off_hi[k] = ov[k][23:8];
            off_lo[k] = ov[k][7:0];
            gn_hi[k]  = gv[k][23:8];
            gn_lo[k]  = gv[k][7:0];
            e[24*k +: 24] = cal(rv[k], ov[k], gv[k]);
        end
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
        chk(96'(secfail), 96'h1, "fail flag after write");
        n = 1;
        while (secfail === 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        chk(96'(n), 96'(ISO + 1), "fail flag span");
        repeat (12) rd(96, f);
        chk(f, e, "calibrated frame");
        $display("calibration test done");
    endtask

    // Channel 0 is the zero-phase reference; others capture later ramp steps
    task automatic t_phase();
        gn_hi   = {16'h8000, 16'h8000, 16'h8000};
        gn_lo   = '0;
        off_hi  = '0;
        off_lo  = '0;
        phase   = {8'h05, 8'h02, 8'h00};
        ramp_on = 1'b1;
        repeat (12) rd(96, f);
        chk(96'(f[47:24] - f[23:0]), 96'h2, "phase step one");
        chk(96'(f[71:48] - f[23:0]), 96'h5, "phase step two");
        rd(48, f);
        chk(96'(data_ready_out_n), 96'h0, "ready after partial read");
        rd(96, g);
        chk(96'(g[95:48]), 96'(f[47:0]), "repeated frame");
        $display("phase and partial read test done");
    endtask

    // Host stalls until the buffer refuses, then drains it in order
    task automatic t_buffer();
        repeat (704) @(negedge clk);
        chk(96'(ovf), 96'h1, "buffer refused frame");
        rd(96, f);
        repeat (4) @(negedge clk);
        chk(96'(ovf), 96'h0, "overflow cleared by read");
        for (int k = 0; k < 7; k++)
        begin
            g = f;
            rd(96, f);
            if (k > 0)
                chk(96'(f[23:0] - g[23:0]), 96'h8, "buffered frames in order");
        end
        $display("buffer test done");
    endtask

    task automatic t_half();
        logic prev;
        fmt = 1'b1;
        repeat (640) @(negedge clk);
        n    = 0;
        prev = data_ready_out_n;
        for (int k = 0; k < 1024; k++)
        begin
            @(negedge clk);
            if (data_ready_out_n === 1'b0 && prev === 1'b1)
                n++;
            prev = data_ready_out_n;
        end
        chk(96'(n), 96'h8, "half rate ready pulses");
        $display("half rate test done");
    endtask

    // Strobe well away from period start, twice, reading in between
    task automatic t_resync();
        for (int k = 0; k < 2; k++)
        begin
            wait_data_ready_out();
            repeat (20) @(negedge clk);
            sync_n = 1'b0;
            repeat (2) @(negedge clk);
            sync_n = 1'b1;
            repeat (40) @(negedge clk);
            chk(96'(resync), 96'h1, "resync flag set");
            rd(96, f);
            chk(96'({f[95], f[92]}), 96'h3, "status resync and format");
            rd(96, f);
            chk(96'(resync), 96'h0, "resync cleared by read");
        end
        $display("resync test done");
    endtask

    // Reset for four cycles, then each scenario
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk(96'({data_ready_out_n, resync, secfail, ovf, miso_oe}), 96'h10, "reset state");
        $display("reset test done");
        t_calib();
        t_phase();
        t_buffer();
        t_half();
        t_resync();
        print_verdict();
    end
endmodule

// ==== hdl/acr_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module acr_fifo #(
    parameter int WIDTH = 96,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    output logic [WIDTH-1:0]      o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } acr_fifo_state_t;

    acr_fifo_state_t st_q;
    acr_fifo_state_t st_d;
    logic            push;
    logic            pop;

    // Flags from the occupancy count
    assign o_in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (st_q.cnt != '0);
    assign o_out_data  = st_q.mem[st_q.rp];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // Pointer wrap works for any depth, not only powers of two
    always_comb
    begin
        st_d = st_q;
        if (push)
        begin
            st_d.mem[st_q.wp] = i_in_data;
            st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + 1'b1;
        end
        if (pop)
        begin
            st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end
endmodule

// ==== hdl/acr_top.sv ====
// Calibration, sync check and serial frame readout of a multichannel converter.
`timescale 1ns/10ps
`include "acr_defines.svh"
module acr_top #(
    parameter int PERIOD_CLKS     = `ACR_PERIOD_CLKS,
    parameter int ISO_XFER_CYCLES = `ACR_ISO_XFER_CYC,
    parameter int FIFO_DEPTH      = 8
) (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_rst,
    input  wire logic                     i_converter_clock_in,
    input  wire logic                     i_sync_reset_n,
    input  wire acr_pkg::acr_chan_words_t i_raw_sample,
    input  wire acr_pkg::acr_cal_high_t   i_chan_offset_cal_high,
    input  wire acr_pkg::acr_cal_low_t    i_chan_offset_cal_low,
    input  wire acr_pkg::acr_cal_high_t   i_chan_gain_cal_high,
    input  wire acr_pkg::acr_cal_low_t    i_chan_gain_cal_low,
    input  wire acr_pkg::acr_phase_t      i_chan_phase_field,
    input  wire logic                     i_ready_format_bit,
    input  wire logic                     i_cfg_write,
    input  wire logic                     i_spi_sclk,
    input  wire logic                     i_spi_cs_n,
    output logic                          o_spi_miso,
    output logic                          o_spi_miso_oe,
    output logic                          o_data_ready_out_n,
    output logic                          o_resync_flag,
    output logic                          o_secondary_fail_flag,
    output logic                          o_overflow_flag
);
    localparam int                      NCH      = `ACR_NCH;
    localparam int                      FW       = `ACR_FRAME_BITS;
    localparam int                      DW       = `ACR_NCH * `ACR_WORD_W;
    localparam logic [`ACR_PHASE_W-1:0] PER_LAST = `ACR_PHASE_W'(PERIOD_CLKS - 1);
    localparam logic [15:0]             XFER_LD  = 16'(ISO_XFER_CYCLES);
    localparam logic [3:0]              DATA_READY_OUT_LD  = 4'(`ACR_DATA_READY_OUT_CYC);
    localparam logic [`ACR_BITCNT_W-1:0] LAST_BIT = `ACR_BITCNT_W'(FW - 1);

    // --------------------
    // System-domain state
    // --------------------
    typedef struct packed {
        logic                     cs_s1;
        logic                     cs_s2;
        logic                     dn_s1;
        logic                     dn_s2;
        logic                     dn_prev;
        logic                     ck_s1;
        logic                     ck_s2;
        logic                     ck_prev;
        logic                     sy_s1;
        logic                     sy_s2;
        logic                     sy_prev;
        logic                     sy_pend;
        logic [`ACR_PHASE_W-1:0]  per_cnt;
        acr_pkg::acr_chan_words_t raw;
        acr_pkg::acr_frame_t      tx;
        logic                     tx_full;
        logic                     skip;
        logic                     resync;
        logic                     secfail;
        logic [15:0]              xfer_cnt;
        logic                     overflow;
        logic                     data_ready_out_n;
        logic [3:0]               data_ready_out_cnt;
    } acr_sys_t;

    acr_sys_t                 s_q;
    acr_sys_t                 s_d;
    acr_pkg::acr_link_t       l_q;
    acr_pkg::acr_link_t       l_d;
    logic                     done_tgl_q;
    logic                     link_rst;
    acr_pkg::acr_chan_words_t cal_word;
    logic                     ck_rise;
    logic                     sy_fall;
    logic                     conv_tick;
    logic                     read_done;
    logic                     fifo_in_ready;
    logic                     fifo_out_valid;
    logic [DW-1:0]            fifo_out_data;
    logic                     fifo_pop;
    logic                     tx_load;

    // --------------------
    // Calibration datapath, one copy per channel
    // --------------------
    // Gain is unsigned with 23 fraction bits, so 24'h80_0000 passes data unchanged.
    // The product saturates rather than wraps; a wrapped reading is far worse.
    generate
        for (genvar ch = 0; ch < NCH; ch++)
        begin : g_cal
            logic signed [24:0] off;
            logic signed [24:0] diff;
            logic signed [24:0] gain;
            logic signed [49:0] prod;
            logic        [26:0] scaled;
            logic               sat;

            assign off    = $signed({i_chan_offset_cal_high[ch][15],
                                     i_chan_offset_cal_high[ch], i_chan_offset_cal_low[ch]});
            assign diff   = $signed({s_q.raw[ch][23], s_q.raw[ch]}) - off;
            assign gain   = $signed({1'b0, i_chan_gain_cal_high[ch], i_chan_gain_cal_low[ch]});
            assign prod   = diff * gain;
            assign scaled = prod[`ACR_GAIN_FRAC+26:`ACR_GAIN_FRAC];
            assign sat    = !((&scaled[26:23]) | (~|scaled[26:23]));
            assign cal_word[ch] = sat ? (scaled[26] ? `ACR_SAT_NEG : `ACR_SAT_POS)
                                      : scaled[23:0];
        end
    endgenerate

    // --------------------
    // Frame buffer between conversion and readout
    // --------------------
    // A full buffer drops new frames and raises the overflow flag
    acr_fifo #(
        .WIDTH (DW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_rst       (i_rst),
        .i_in_data   (cal_word),
        .i_in_valid  (conv_tick),
        .o_in_ready  (fifo_in_ready),
        .o_out_data  (fifo_out_data),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_pop)
    );

    // Edge events seen only through the second synchroniser stage
    assign ck_rise   = s_q.ck_s2 & ~s_q.ck_prev;
    // A sync edge is held until the next converter edge, or it would be missed
    assign sy_fall   = (~s_q.sy_s2 & s_q.sy_prev) | s_q.sy_pend;
    assign conv_tick = ck_rise & (s_q.per_cnt == PER_LAST);
    assign read_done = s_q.dn_s2 ^ s_q.dn_prev;

    // Pop only while the link is idle, so the frame never changes under a read.
    // With the pulse format an unread frame is replaced by every other one.
    assign fifo_pop = fifo_out_valid & s_q.cs_s2 & ~read_done
                    & (~s_q.tx_full | i_ready_format_bit);
    assign tx_load  = fifo_pop & (~s_q.tx_full | s_q.skip);

    // --------------------
    // System-domain next state
    // --------------------
    always_comb
    begin
        s_d         = s_q;
        s_d.cs_s1   = i_spi_cs_n;
        s_d.cs_s2   = s_q.cs_s1;
        s_d.dn_s1   = done_tgl_q;
        s_d.dn_s2   = s_q.dn_s1;
        s_d.dn_prev = s_q.dn_s2;
        s_d.ck_s1   = i_converter_clock_in;
        s_d.ck_s2   = s_q.ck_s1;
        s_d.ck_prev = s_q.ck_s2;
        s_d.sy_s1   = i_sync_reset_n;
        s_d.sy_s2   = s_q.sy_s1;
        s_d.sy_prev = s_q.sy_s2;
        s_d.sy_pend = sy_fall & ~ck_rise;

        // Free-running conversion period in converter clocks; the sync pin
        // never starts it, it only pulls the count back into step
        if (ck_rise)
        begin
            s_d.per_cnt = (s_q.per_cnt == PER_LAST) ? '0 : s_q.per_cnt + 1'b1;
            for (int ch = 0; ch < NCH; ch++)
            begin
                if (s_q.per_cnt == i_chan_phase_field[ch])
                    s_d.raw[ch] = i_raw_sample[ch];
            end
            if (sy_fall && s_q.per_cnt != '0)
                s_d.per_cnt = '0;
        end

        // Frame read: release the buffer and clear the read-to-clear flags
        if (read_done)
        begin
            s_d.tx_full  = 1'b0;
            s_d.skip     = 1'b0;
            s_d.resync   = 1'b0;
            s_d.overflow = 1'b0;
            s_d.data_ready_out_n   = 1'b1;
            s_d.data_ready_out_cnt = '0;
        end

        // Sync edge off the period boundary; set wins over the read clear
        if (ck_rise && sy_fall && s_q.per_cnt != '0)
            s_d.resync = 1'b1;
        if (conv_tick && !fifo_in_ready)
            s_d.overflow = 1'b1;

        // Load the link frame; data-ready falls on buffer updates only
        if (fifo_pop && s_q.tx_full)
            s_d.skip = ~s_q.skip;
        if (tx_load)
        begin
            s_d.tx.data   = fifo_out_data;
            s_d.tx.status = {s_d.resync, s_q.secfail, s_d.overflow,
                             i_ready_format_bit, 20'h0_0000};
            s_d.tx_full   = 1'b1;
            s_d.skip      = 1'b0;
            s_d.data_ready_out_n    = 1'b0;
            s_d.data_ready_out_cnt  = DATA_READY_OUT_LD;
        end
        else if (i_ready_format_bit && s_q.data_ready_out_cnt != '0)
        begin
            // Pulse format: data-ready returns high after a short low pulse
            s_d.data_ready_out_cnt = s_q.data_ready_out_cnt - 1'b1;
            if (s_q.data_ready_out_cnt == 4'h1)
                s_d.data_ready_out_n = 1'b1;
        end

        // Barrier transfer after a configuration write holds the fail flag
        if (i_cfg_write)
        begin
            s_d.secfail  = 1'b1;
            s_d.xfer_cnt = XFER_LD;
        end
        else if (s_q.xfer_cnt != '0)
        begin
            s_d.xfer_cnt = s_q.xfer_cnt - 1'b1;
            if (s_q.xfer_cnt == 16'h0001)
                s_d.secfail = 1'b0;
        end
    end

    // System-domain register; idle lines reset high so no false edges appear
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_q         <= '0;
            s_q.cs_s1   <= 1'b1;
            s_q.cs_s2   <= 1'b1;
            s_q.sy_s1   <= 1'b1;
            s_q.sy_s2   <= 1'b1;
            s_q.sy_prev <= 1'b1;
            s_q.data_ready_out_n  <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // --------------------
    // Link domain: serial shifter on the host clock
    // --------------------
    // Chip select high clears the shifter at once, which releases the data line
    // without needing a clock edge. The frame is read across domains as a held
    // word: it only changes while the system side sees chip select high.
    assign link_rst = i_rst | i_spi_cs_n;

    always_comb
    begin
        l_d    = l_q;
        l_d.oe = 1'b1;
        if (l_q.cnt == '0)
        begin
            l_d.dout = s_q.tx[FW-1];
            l_d.sh   = {s_q.tx[FW-2:0], 1'b0};
        end
        else
        begin
            l_d.dout = l_q.sh[FW-1];
            l_d.sh   = {l_q.sh[FW-2:0], 1'b0};
        end
        if (l_q.cnt != `ACR_BITCNT_W'(FW))
            l_d.cnt = l_q.cnt + 1'b1;
    end

    // Shifter register, cleared while deselected
    always_ff @(posedge i_spi_sclk or posedge link_rst)
    begin
        if (link_rst)
            l_q <= '0;
        else
            l_q <= l_d;
    end

    // Completion toggle survives deselect; flipped only once the last word leaves
    always_ff @(posedge i_spi_sclk or posedge i_rst)
    begin
        if (i_rst)
            done_tgl_q <= 1'b0;
        else if (!i_spi_cs_n && l_q.cnt == LAST_BIT)
            done_tgl_q <= ~done_tgl_q;
    end

    // --------------------
    // Outputs, all straight from flip-flops
    // --------------------
    assign o_spi_miso            = l_q.dout;
    assign o_spi_miso_oe         = l_q.oe;
    assign o_data_ready_out_n    = s_q.data_ready_out_n;
    assign o_resync_flag         = s_q.resync;
    assign o_secondary_fail_flag = s_q.secfail;
    assign o_overflow_flag       = s_q.overflow;
endmodule

// ==== pkg/acr_defines.svh ====
// Constants of the calibration and readout block: sizes, reset values, timing.
//
// How it works
// - Serial data output is released whenever chip select is high.
// - Each channel takes its own phase; host tracks the zero-phase channel.
// - Programmed offset (high and low parts) is subtracted from each result.
// - Offset-corrected result is multiplied by the channel gain factor every sample.
// - Each channel samples shifted by its phase field from the reference.
// - Data-ready follows frame updates in the output buffer, not conversions.
// - Format bit set and no reads: buffer refreshes every other conversion.
// - Sync edge out of step with converter clock sets resync flag again.
// - Sync input only pulls the period count back into step; conversions never start from it.
// - Frame counts as read only after all words shift out; else repeated.
// - Configuration write sets secondary-fail until barrier transfer finishes.
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define ACR_NCH          3
`define ACR_WORD_W       24
`define ACR_FRAME_WORDS  4
`define ACR_FRAME_BITS   96
`define ACR_BITCNT_W     7
`define ACR_PHASE_W      8
`define ACR_GAIN_FRAC    23

// ----------------------------------------------------------------------------
// Reset values and saturation limits
// ----------------------------------------------------------------------------
`define ACR_RST_WORD     24'h00_0000
`define ACR_SAT_POS      24'h7F_FFFF
`define ACR_SAT_NEG      24'h80_0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ACR_SYS_CLK_KHZ  50000
`define ACR_ISO_XFER_NS  2000
`define ACR_ISO_XFER_CYC ((`ACR_ISO_XFER_NS * `ACR_SYS_CLK_KHZ) / 1000000)
`define ACR_DATA_READY_OUT_NS      40
`define ACR_DATA_READY_OUT_CYC     ((`ACR_DATA_READY_OUT_NS * `ACR_SYS_CLK_KHZ + 999999) / 1000000)
`define ACR_PERIOD_CLKS  128

`endif

// ==== pkg/acr_pkg.sv ====
// Types shared by the calibration and readout block.
`include "acr_defines.svh"
package acr_pkg;

    typedef logic [`ACR_WORD_W-1:0]                 acr_word_t;
    typedef logic [`ACR_NCH-1:0][`ACR_WORD_W-1:0]   acr_chan_words_t;
    typedef logic [`ACR_NCH-1:0][`ACR_PHASE_W-1:0]  acr_phase_t;
    typedef logic [`ACR_NCH-1:0][15:0]              acr_cal_high_t;
    typedef logic [`ACR_NCH-1:0][7:0]               acr_cal_low_t;

    // Frame shipped to the link: status word then one word per channel
    typedef struct packed {
        acr_word_t       status;
        acr_chan_words_t data;
    } acr_frame_t;

    // Link-side shifter state, clocked by the serial clock
    typedef struct packed {
        logic [`ACR_BITCNT_W-1:0]  cnt;
        logic [`ACR_FRAME_BITS-1:0] sh;
        logic                      dout;
        logic                      oe;
    } acr_link_t;

endpackage
